// File: common/eqs_pkg.sv
// ============================================================
// egress queue scheduler: shared constants and carriers
package eqs_pkg;

  // queue and port geometry
  localparam int NUM_QUEUES = 8;
  localparam int QW         = 3;
  localparam int NUM_PORTS  = 4;
  localparam int PW         = 2;
  localparam int WEIGHT_W   = 4;
  localparam int LEN_W      = 11;
  localparam int DEF_W      = 14;
  localparam int FIFO_DEPTH = 8;

  // legal weight range; zero is refused at write time
  localparam logic [WEIGHT_W-1:0] WEIGHT_MIN = 4'h1;
  localparam logic [WEIGHT_W-1:0] WEIGHT_MAX = 4'hF;

  // bytes of credit per weight unit in weighted fair mode
  localparam logic [7:0] QUANTUM_BYTES = 8'h80;

  // all queues may join the strict tier
  localparam logic [NUM_QUEUES-1:0] ALL_QUEUES = 8'hFF;

  typedef enum logic [1:0] {
    STRICT_PRIORITY_MODE,
    WEIGHTED_FAIR_MODE,
    WEIGHTED_ROUND_ROBIN_MODE
  } eqs_mode_type;

  // one port's scheduler settings
  typedef struct packed {
    eqs_mode_type                           mode;
    logic                                   floor_none;
    logic [QW-1:0]                          strict_tier_floor_queue;
    logic [NUM_QUEUES-1:0][WEIGHT_W-1:0]    weight;
  } eqs_cfg_type;

  // weights reset to queue number plus one
  localparam logic [NUM_QUEUES*WEIGHT_W-1:0] WEIGHT_RESET = 32'h8765_4321;
  localparam eqs_cfg_type CFG_RESET = '{
    mode:                    STRICT_PRIORITY_MODE,
    floor_none:              1'b1,
    strict_tier_floor_queue: 3'h0,
    weight:                  WEIGHT_RESET
  };

  // queue occupancy as seen by the scheduler
  typedef struct packed {
    logic [NUM_QUEUES-1:0]             nonempty;
    logic [NUM_QUEUES-1:0][LEN_W-1:0]  head_len;
  } eqs_qstat_type;

  // one transmit grant
  typedef struct packed {
    logic [QW-1:0]    queue;
    logic [LEN_W-1:0] len;
  } eqs_grant_type;

  localparam int GRANT_W = $bits(eqs_grant_type);

endpackage

// File: core/eqs_scheduler.sv
// Contract
// R1: strict mode serves highest non-empty queue; seven top, zero last
// R2: strict mode drops lower only when all higher queues are empty
// R3: weighted fair mode gives bandwidth shares in proportion to weight
// R4: round robin rotates queues; service per turn grows with weight
// R5: eight separate weights, used only in the two weighted modes
// R6: strict tier floor applies only in weighted modes
// R7: floor queue and above served strictly ahead of weighted queues
// R8: floor setting none schedules all queues by weighted mode only
// R9: settings per port; all-ports write copies to every port at once
// R10: weights accept 1 to 15 only; other values are never used
// R11: after reset each weight equals its queue number plus one
// R12: weighting shapes only under congestion; else traffic flows free
// R13: round robin skips empty queues, returns to queues holding frames
// R14: never grant an empty queue; no grant when all queues are empty
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// grant fifo with a registered head word
module eqs_fifo
  import eqs_pkg::*;
#(
  parameter int WIDTH = GRANT_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             CLK_SYS,
  input  wire logic             SYS_RST,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_q, rd_d, wr_q, wr_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             hv_q, hv_d;
  logic [WIDTH-1:0] head_q, head_d;
  logic             push, pop, head_free, to_mem;

  // head word is a flop so the transmit side sees registered data
  always_comb begin
    in_ready  = (cnt_q < (AW+1)'(DEPTH));
    push      = in_valid && in_ready;
    pop       = hv_q && out_ready;
    head_free = !hv_q || pop;
    to_mem    = push && !(head_free && (cnt_q == '0));
    rd_d      = rd_q;
    wr_d      = wr_q;
    cnt_d     = cnt_q;
    hv_d      = hv_q;
    head_d    = head_q;
    if (head_free) begin
      if (cnt_q != '0) begin
        head_d = mem[rd_q];
        hv_d   = 1'b1;
        rd_d   = rd_q + 1'b1;
        cnt_d  = cnt_d - 1'b1;
      end else if (push) begin
        head_d = in_data;
        hv_d   = 1'b1;
      end else begin
        hv_d   = 1'b0;
      end
    end
    if (to_mem) begin
      wr_d  = wr_q + 1'b1;
      cnt_d = cnt_d + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rd_q   <= '0;
      wr_q   <= '0;
      cnt_q  <= '0;
      hv_q   <= 1'b0;
      head_q <= '0;
    end else begin
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      cnt_q  <= cnt_d;
      hv_q   <= hv_d;
      head_q <= head_d;
    end
  end

  // storage needs no reset, the count guards it
  always_ff @(posedge CLK_SYS) begin
    if (to_mem) begin
      mem[wr_q] <= in_data;
    end
  end

  assign out_valid = hv_q;
  assign out_data  = head_q;
endmodule

// ============================================================
// eight-queue egress scheduler
module eqs_scheduler
  import eqs_pkg::*;
(
  input  wire logic           CLK_SYS,
  input  wire logic           SYS_RST,
  input  wire logic           CFG_WE,
  input  wire logic           CFG_ALL_PORTS,
  input  wire logic [PW-1:0]  CFG_PORT,
  input  wire eqs_cfg_type    CFG_WORD,
  input  wire logic [PW-1:0]  CFG_RD_PORT,
  output eqs_cfg_type         CFG_RD_WORD,
  input  wire logic [PW-1:0]  SCHED_PORT,
  input  wire logic           PORT_CONGESTED,
  input  wire eqs_qstat_type  Q_STATUS,
  output logic                Q_DEQ_VALID,
  output logic [QW-1:0]       Q_DEQ_QUEUE,
  output logic                TX_VALID,
  input  wire logic           TX_READY,
  output eqs_grant_type       TX_GRANT
);

  typedef enum logic {ST_PICK, ST_SETTLE} eqs_state_type;

  // highest set bit of a queue mask
  function automatic logic [QW-1:0] top_index(input logic [7:0] m);
    logic [QW-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_QUEUES; i++) begin
      if (m[i]) r = QW'(i);
    end
    return r;
  endfunction

  // first set bit after cur, wrapping; cur itself comes last
  function automatic logic [QW-1:0] next_after(input logic [7:0] m,
                                               input logic [QW-1:0] cur);
    logic [QW-1:0] r;
    logic [QW-1:0] idx;
    logic          hit;
    r   = cur;
    hit = 1'b0;
    for (int k = 1; k <= NUM_QUEUES; k++) begin
      idx = cur + QW'(k);
      if (m[idx] && !hit) begin
        r   = idx;
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // ============================================================
  // per-port settings table
  eqs_cfg_type tbl_q [NUM_PORTS];
  eqs_cfg_type tbl_d [NUM_PORTS];
  eqs_cfg_type rd_q, rd_d;

  // all-ports write lands in every entry on the same edge
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      tbl_d[p] = tbl_q[p];
      if (CFG_WE && (CFG_ALL_PORTS || CFG_PORT == PW'(p))) begin // R9
        // an unknown mode code keeps the old mode
        if (CFG_WORD.mode == STRICT_PRIORITY_MODE ||
            CFG_WORD.mode == WEIGHTED_FAIR_MODE ||
            CFG_WORD.mode == WEIGHTED_ROUND_ROBIN_MODE) begin
          tbl_d[p].mode = CFG_WORD.mode;
        end
        tbl_d[p].floor_none              = CFG_WORD.floor_none;
        tbl_d[p].strict_tier_floor_queue = CFG_WORD.strict_tier_floor_queue;
        for (int q = 0; q < NUM_QUEUES; q++) begin
          if (CFG_WORD.weight[q] >= WEIGHT_MIN &&
              CFG_WORD.weight[q] <= WEIGHT_MAX) begin // R10
            tbl_d[p].weight[q] = CFG_WORD.weight[q]; // R5
          end
        end
      end
    end
    rd_d = tbl_q[CFG_RD_PORT];
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        tbl_q[p] <= CFG_RESET; // R11
      end
      rd_q <= CFG_RESET;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        tbl_q[p] <= tbl_d[p];
      end
      rd_q <= rd_d;
    end
  end

  assign CFG_RD_WORD = rd_q;

  // ============================================================
  // selection
  eqs_cfg_type           cfg;
  logic [7:0]            ne, strict_mask, strict_cand, wt_cand;
  logic                  weighted, cur_ok, cong, fifo_ready, push;
  logic [QW-1:0]         nxt, pick;
  logic                  pick_valid;
  logic [DEF_W-1:0]      sum;
  logic [QW-1:0]         rr_q, rr_d;
  logic [WEIGHT_W-1:0]   credit_q, credit_d;
  logic [DEF_W-1:0]      def_q [NUM_QUEUES];
  logic [DEF_W-1:0]      def_d [NUM_QUEUES];
  eqs_state_type         st_q, st_d;
  logic                  deq_v_q, deq_v_d;
  logic [QW-1:0]         deq_q_q, deq_q_d;
  eqs_grant_type         grant;

  always_comb begin
    cfg      = tbl_q[SCHED_PORT];
    ne       = Q_STATUS.nonempty;
    cong     = PORT_CONGESTED;
    weighted = (cfg.mode == WEIGHTED_FAIR_MODE) ||
               (cfg.mode == WEIGHTED_ROUND_ROBIN_MODE);
    // floor only matters in weighted modes
    if (!weighted) begin
      strict_mask = ALL_QUEUES; // R6
    end else if (cfg.floor_none) begin
      strict_mask = '0; // R8
    end else begin
      strict_mask = ALL_QUEUES << cfg.strict_tier_floor_queue; // R7
    end
    strict_cand = ne & strict_mask; // R14
    wt_cand     = ne & ~strict_mask;
    cur_ok      = wt_cand[rr_q];
    nxt         = next_after(wt_cand, rr_q); // R13
    sum         = '0;
    pick        = '0;
    pick_valid  = 1'b0;
    rr_d        = rr_q;
    credit_d    = cur_ok ? credit_q : '0; // stale turn never carries over
    for (int q = 0; q < NUM_QUEUES; q++) begin
      // drained queues lose their banked credit
      def_d[q] = wt_cand[q] ? def_q[q] : '0;
    end
    if (strict_cand != '0) begin
      pick       = top_index(strict_cand); // R1 R2
      pick_valid = 1'b1;
    end else if (wt_cand != '0 &&
                 cfg.mode == WEIGHTED_ROUND_ROBIN_MODE) begin
      // credit counts frames left in the current turn
      if (cur_ok && (credit_q != '0 || !cong)) begin // R12
        pick       = rr_q;
        pick_valid = 1'b1;
        if (cong) credit_d = credit_q - 1'b1;
      end else begin
        pick       = nxt; // R4
        pick_valid = 1'b1;
        rr_d       = nxt;
        credit_d   = cong ? cfg.weight[nxt] - 1'b1 : cfg.weight[nxt]; // R4
      end
    end else if (wt_cand != '0) begin
      // deficit counting in bytes, quantum scales with weight
      if (cur_ok &&
          (!cong || def_q[rr_q] >= DEF_W'(Q_STATUS.head_len[rr_q]))) begin
        pick       = rr_q;
        pick_valid = 1'b1;
        if (cong) begin
          def_d[rr_q] = def_q[rr_q] - DEF_W'(Q_STATUS.head_len[rr_q]); // R3
        end
      end else begin
        sum = def_q[nxt] + DEF_W'(cfg.weight[nxt]) * DEF_W'(QUANTUM_BYTES);
        rr_d       = nxt;
        def_d[nxt] = sum;
        if (!cong || sum >= DEF_W'(Q_STATUS.head_len[nxt])) begin // R12
          pick       = nxt;
          pick_valid = 1'b1;
          if (cong) def_d[nxt] = sum - DEF_W'(Q_STATUS.head_len[nxt]);
        end
      end
    end
  end

  // one grant, then a settle cycle so queue status can catch up
  always_comb begin
    push        = (st_q == ST_PICK) && pick_valid && fifo_ready; // R14
    grant.queue = pick;
    grant.len   = Q_STATUS.head_len[pick];
    deq_v_d     = push;
    deq_q_d     = push ? pick : deq_q_q;
    unique case (st_q)
      ST_PICK:   st_d = push ? ST_SETTLE : ST_PICK;
      ST_SETTLE: st_d = ST_PICK;
    endcase
  end

  // weighted state commits only when the pick cycle can push
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      st_q     <= ST_PICK;
      rr_q     <= '0;
      credit_q <= '0;
      deq_v_q  <= 1'b0;
      deq_q_q  <= '0;
      for (int q = 0; q < NUM_QUEUES; q++) begin
        def_q[q] <= '0;
      end
    end else begin
      st_q    <= st_d;
      deq_v_q <= deq_v_d;
      deq_q_q <= deq_q_d;
      if (st_q == ST_PICK && fifo_ready) begin
        rr_q     <= rr_d;
        credit_q <= credit_d;
        for (int q = 0; q < NUM_QUEUES; q++) begin
          def_q[q] <= def_d[q];
        end
      end
    end
  end

  assign Q_DEQ_VALID = deq_v_q;
  assign Q_DEQ_QUEUE = deq_q_q;

  // ============================================================
  // grants buffered toward the transmit path
  eqs_fifo #(
    .WIDTH (GRANT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK_SYS   (CLK_SYS),
    .SYS_RST   (SYS_RST),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   (grant),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (TX_GRANT)
  );

endmodule

`default_nettype wire

// File: testbench/eqs_scheduler_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// port-level checks of the egress scheduler
module eqs_sched_chk
  import eqs_pkg::*;
(
  input wire logic          CLK_SYS,
  input wire logic          SYS_RST,
  input wire logic          CFG_WE,
  input wire logic          CFG_ALL_PORTS,
  input wire logic [PW-1:0] CFG_PORT,
  input wire eqs_cfg_type   CFG_WORD,
  input wire logic [PW-1:0] CFG_RD_PORT,
  input wire eqs_cfg_type   CFG_RD_WORD,
  input wire logic [PW-1:0] SCHED_PORT,
  input wire eqs_qstat_type Q_STATUS,
  input wire logic          Q_DEQ_VALID,
  input wire logic [QW-1:0] Q_DEQ_QUEUE,
  input wire logic          TX_VALID,
  input wire logic          TX_READY,
  input wire eqs_grant_type TX_GRANT
);
  default clocking dc @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // a zero weight nibble leaves the stored weight alone
  function automatic logic [31:0] merge(logic [31:0] nw, logic [31:0] od);
    for (int k = 0; k < 32; k += 4) begin
      merge[k+:4] = (nw[k+:4] == 4'h0) ? od[k+:4] : nw[k+:4];
    end
  endfunction

  // grant whose settings also show on the readback port
  sequence s_pick;
    Q_DEQ_VALID && $past(CFG_RD_PORT == SCHED_PORT);
  endsequence

  // isolated write to the watched port, then a quiet cycle
  sequence s_wr;
    CFG_WE && !$past(CFG_WE) && $stable(CFG_RD_PORT)
      && (CFG_ALL_PORTS || CFG_PORT == CFG_RD_PORT)
      ##1 !CFG_WE && $stable(CFG_RD_PORT);
  endsequence

  AST_DEQ_SPACED: assert property (
    Q_DEQ_VALID |=> !Q_DEQ_VALID)
    else $error("grants closer than two cycles");
  AST_DEQ_NONEMPTY: assert property (
    Q_DEQ_VALID |-> (($past(Q_STATUS.nonempty) >> Q_DEQ_QUEUE) & 8'h01) != 0)
    else $error("grant from an empty queue");
  AST_STRICT_TOP: assert property (
    s_pick ##0 CFG_RD_WORD.mode == STRICT_PRIORITY_MODE
    |-> ($past(Q_STATUS.nonempty) >> Q_DEQ_QUEUE) == 8'h01)
    else $error("strict grant skipped a higher queue");
  AST_TIER_FIRST: assert property (
    s_pick ##0 (CFG_RD_WORD.mode != STRICT_PRIORITY_MODE
      && !CFG_RD_WORD.floor_none && ($past(Q_STATUS.nonempty)
      >> CFG_RD_WORD.strict_tier_floor_queue) != 0)
    |-> ($past(Q_STATUS.nonempty) >> Q_DEQ_QUEUE) == 8'h01)
    else $error("strict tier not served first");
  AST_TX_HOLD: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_GRANT))
    else $error("grant head changed while stalled");
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    SYS_RST |=> !TX_VALID && !Q_DEQ_VALID && CFG_RD_WORD == CFG_RESET)
    else $error("reset state wrong");
  AST_CFG_WEIGHT: assert property (
    s_wr |=> CFG_RD_WORD.weight ==
      merge($past(CFG_WORD.weight, 2), $past(CFG_RD_WORD.weight, 2)))
    else $error("weights not stored as written");
  AST_CFG_MODE: assert property (
    s_wr ##0 $past(CFG_WORD.mode) != 2'h3 |=>
      CFG_RD_WORD.mode == $past(CFG_WORD.mode, 2) &&
      CFG_RD_WORD.floor_none == $past(CFG_WORD.floor_none, 2))
    else $error("mode not stored as written");
endmodule

bind eqs_scheduler eqs_sched_chk u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CFG_WE(CFG_WE),
  .CFG_ALL_PORTS(CFG_ALL_PORTS), .CFG_PORT(CFG_PORT), .CFG_WORD(CFG_WORD),
  .CFG_RD_PORT(CFG_RD_PORT), .CFG_RD_WORD(CFG_RD_WORD),
  .SCHED_PORT(SCHED_PORT), .Q_STATUS(Q_STATUS), .Q_DEQ_VALID(Q_DEQ_VALID),
  .Q_DEQ_QUEUE(Q_DEQ_QUEUE), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX_GRANT(TX_GRANT));

`default_nettype wire

// File: testbench/eqs_tx_sink.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// transmit path model: takes grants, stalls at will
module eqs_tx_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  input  wire logic tx_valid,
  output logic      tx_ready,
  output int        taken
);
  logic [7:0] lfsr_q;

  // pseudo-random ready gives both prompt and slow acceptance
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_q <= 8'hA5;
      tx_ready <= 1'b0;
      taken <= 0;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      tx_ready <= !stall && lfsr_q[0];
      if (tx_valid && tx_ready) begin
        taken <= taken + 1;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/eqs_scheduler_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// egress scheduler bench
module eqs_scheduler_tb
  import eqs_pkg::*;
;
  logic          clk = 1'b0, rst = 1'b1, we = 1'b0, all = 1'b0;
  logic          cg = 1'b1, stall = 1'b0, dv, tv, tr;
  logic [PW-1:0] port = '0, rdp = '0;
  logic [QW-1:0] dq, txq[$];
  logic [31:0]   seed = 32'h17493127;
  eqs_cfg_type   word = CFG_RESET, rdw;
  eqs_qstat_type qs;
  eqs_grant_type tg;
  int            cnt[8], gq[8], exp_q[$], thr, b, g;
  int            ndeq, taken, cyc, mismatches, num_checks;

  // 125 MHz system clock
  always #4 clk = ~clk;

  eqs_scheduler DUT (
    .CLK_SYS(clk), .SYS_RST(rst), .CFG_WE(we), .CFG_ALL_PORTS(all),
    .CFG_PORT(port), .CFG_WORD(word), .CFG_RD_PORT(rdp), .CFG_RD_WORD(rdw),
    .SCHED_PORT(rdp), .PORT_CONGESTED(cg), .Q_STATUS(qs), .Q_DEQ_VALID(dv),
    .Q_DEQ_QUEUE(dq), .TX_VALID(tv), .TX_READY(tr), .TX_GRANT(tg));
  eqs_tx_sink u_sink (.clk(clk), .rst(rst), .stall(stall), .tx_valid(tv),
    .tx_ready(tr), .taken(taken));

  // ============================================================
  // helpers
  task automatic check(input logic [63:0] gv, input logic [63:0] ev);
    num_checks++;
    if (gv !== ev) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, gv, ev);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic a, input logic [PW-1:0] p,
                    input eqs_cfg_type w);
    all <= a;
    port <= p;
    word <= w;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [PW-1:0] p, input eqs_cfg_type e);
    rdp <= p;
    repeat (2) @(posedge clk);
    #1 check(rdw, e);
    @(posedge clk);
  endtask

  // all-ports write; thr is the lowest queue served strictly
  task automatic cfg(input eqs_mode_type m, input logic fn,
                     input logic [2:0] fl, input logic [31:0] w);
    eqs_cfg_type c;
    c = '{m, fn, fl, w};
    thr = (m == STRICT_PRIORITY_MODE) ? 0 : (fn ? 8 : fl);
    wr(1'b1, seed[1:0], c);
    rd(seed[3:2], c);
  endtask

  // strict part of the backlog has a known order
  task automatic load(input int n[8]);
    for (int q = 7; q >= 0; q--) begin
      if (q >= thr) repeat (n[q]) exp_q.push_back(q);
      cnt[q] <= n[q];
    end
  endtask

  task automatic drain();
    repeat (2) @(posedge clk);
    for (int i = 0; i < 3000 && (cnt.sum() != 0 || taken != ndeq); i++)
      @(posedge clk);
    check(cnt.sum(), 0);
    check(taken, ndeq);
    check(exp_q.size(), 0);
    $display("test done at %0t", $time);
  endtask

  // ============================================================
  // queue manager and grant monitor; status follows each grant
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      qs.nonempty[i] = cnt[i] != 0;
      qs.head_len[i] = 11'h040;
    end
  end

  always @(posedge clk) begin
    if (dv) begin
      ndeq <= ndeq + 1;
      gq[dq] <= gq[dq] + 1;
      cnt[dq] <= cnt[dq] - 1;
      check(cnt[dq] != 0, 1'b1);
      if (exp_q.size() != 0) check(dq, exp_q.pop_front());
      txq.push_back(dq);
    end
    // grants leave the buffer in dequeue order with the head length
    if (tv && tr) check(tg, {txq.pop_front(), 11'h040});
  end

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    eqs_cfg_type c, e;
    int n[8];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) rd(PW'(p), CFG_RESET);
    // zero weight and mode code 3 are refused, per-port write wins
    c = CFG_RESET;
    c.mode = WEIGHTED_ROUND_ROBIN_MODE;
    c.weight[2] = 4'h0;
    e = c;
    e.weight[2] = 4'h3;
    wr(1'b1, 2'h0, c);
    for (int p = 0; p < 4; p++) rd(PW'(p), e);
    e.mode = STRICT_PRIORITY_MODE;
    wr(1'b0, 2'h1, e);
    c = e;
    c.mode = eqs_mode_type'(2'h3);
    wr(1'b0, 2'h1, c);
    rd(2'h1, e);
    e.mode = WEIGHTED_ROUND_ROBIN_MODE;
    rd(2'h2, e);
    // every mode, random floor and backlog; last run uncongested
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      cg <= k != 5;
      cfg(k == 0 ? STRICT_PRIORITY_MODE : k % 2 ? WEIGHTED_FAIR_MODE
          : WEIGHTED_ROUND_ROBIN_MODE, k == 3 || k == 4, seed[6:4],
          lfsr(seed) | 32'h1111_1111);
      for (int q = 0; q < 8; q++) begin
        seed = lfsr(seed);
        n[q] = seed[1:0];
      end
      load(n);
      drain();
    end
    // weight 4 against weight 1: eight of the first ten grants
    cg <= 1'b1; // weights only shape a congested port
    for (int k = 1; k < 3; k++) begin
      cfg(eqs_mode_type'(k), 1'b1, 3'h0, 32'h1111_1411);
      load('{0, 8, 16, 0, 0, 0, 0, 0});
      b = ndeq;
      g = gq[2];
      for (int i = 0; i < 500 && ndeq < b + 10; i++) @(posedge clk);
      #1 check(gq[2] - g, 8);
      @(posedge clk);
      drain();
    end
    // stalled transmit side: buffer fills, then grants stop
    stall <= 1'b1;
    cfg(STRICT_PRIORITY_MODE, 1'b1, 3'h0, 32'h8765_4321);
    b = ndeq;
    load('{0, 0, 0, 12, 0, 0, 0, 0});
    repeat (60) @(posedge clk);
    check(ndeq - b, FIFO_DEPTH + 1);
    stall <= 1'b0;
    drain();
    conclude();
  end
endmodule

`default_nettype wire
